// ---- tb/fep_mac_model.sv ----
// Media access controller model that sends frames on the nibble transmit interface
`timescale 1ns/1ps
module fep_mac_model (
  // Clocks
  input  wire logic            sys_clk,
  input  wire logic            tx_clk,
  // Nibble transmit interface
  output fep_pkg::fep_mii_tx_s mii_tx
);
  logic [3:0] exp_q[$];

  initial mii_tx = '0;

  // Change just after the sampling edge, hold until the next one
  task automatic next_slot();
    @(posedge tx_clk);
    @(negedge sys_clk);
  endtask : next_slot

  task automatic send_frame(input int len);
    logic [3:0] n;
    for (int i = 0; i < 16 + len; i++)
    begin
      n = (i < 15) ? 4'h5 : (i == 15) ? 4'hD : 4'($urandom);
      next_slot();
      mii_tx = '{en: 1'b1, txd: n};
      if (i >= 2)
        exp_q.push_back(n);
    end
    next_slot();
    mii_tx = '{en: 1'b0, txd: 4'($urandom)};
  endtask : send_frame
endmodule : fep_mac_model

// ---- tb/testbench.sv ----
// Self-checking bench for the coding datapath, frames looped back to the receive side
`timescale 1ns/1ps
module testbench;
  logic                 sys_clk;
  logic                 sys_rst;
  logic [15:0]          basic_control_reg;
  logic [15:0]          xcvr_config_reg;
  logic                 full_duplex;
  logic                 speed_10m;
  logic                 man_tx_bit;
  logic                 man_line_bit;
  logic                 tx_clk;
  logic                 rx_clk;
  logic                 rxc_q;
  logic                 crs;
  logic                 col;
  logic                 col_seen;
  logic                 crs_seen;
  logic                 tx_line_en;
  logic                 man_cdr_bit;
  logic [1:0]           tx_line_sym;
  logic [1:0]           rx_line_sym;
  logic [1:0]           far_sym;
  logic                 far_on;
  logic [1:0]           pv;
  logic [1:0]           lnz;
  logic [1:0]           ex;
  logic [4:0]           cfg [5];
  logic [31:0]          seed;
  fep_pkg::fep_mii_tx_s mii_tx;
  fep_pkg::fep_mii_rx_s mii_rx;
  int                   mismatches;
  int                   samples_checked;

  initial sys_clk = 1'b0;
  always #2 sys_clk = ~sys_clk;

  // Cable loop from the line driver, or a far end driving the receiver
  assign rx_line_sym = far_on ? far_sym : tx_line_sym;

  fep_datapath #(.TX_SEED(10'h155), .RX_SEED(10'h3FF)) uut (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .basic_control_reg(basic_control_reg),
    .xcvr_config_reg(xcvr_config_reg), .full_duplex(full_duplex), .speed_10m(speed_10m),
    .mii_tx(mii_tx), .tx_clk(tx_clk), .mii_rx(mii_rx), .rx_clk(rx_clk), .crs(crs),
    .col(col), .tx_line_sym(tx_line_sym), .tx_line_en(tx_line_en),
    .rx_line_sym(rx_line_sym), .man_tx_bit(man_tx_bit), .man_line_bit(man_line_bit),
    .man_cdr_bit(man_cdr_bit));

  fep_mac_model mac (.sys_clk(sys_clk), .tx_clk(tx_clk), .mii_tx(mii_tx));

  task automatic check(input string nm, input logic [7:0] e, input logic [7:0] g);
    samples_checked++;
    if (g !== e)
    begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask : check

  task automatic close_out();
    $display("Comparisons %0d, mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : close_out

  // Each new receive nibble is matched against the oldest sent one
  always @(negedge sys_clk)
  begin
    rxc_q <= rx_clk;
    if (col === 1'b1)
      col_seen <= 1'b1;
    if (crs === 1'b1)
      crs_seen <= 1'b1;
    if (rx_clk === 1'b1 && rxc_q === 1'b0 && mii_rx.dv === 1'b1)
    begin
      if (mac.exp_q.size() == 0)
        check("rx nibble count", 8'h00, 8'h01);
      else
        check("rx nibble", {4'h0, mac.exp_q.pop_front()}, {4'h0, mii_rx.rxd});
    end
  end

  initial
  begin
    sys_rst = 1'b1;
    basic_control_reg = 16'h0000;
    xcvr_config_reg = 16'h0000;
    full_duplex = 1'b0;
    speed_10m = 1'b0;
    man_tx_bit = 1'b0;
    man_line_bit = 1'b0;
    far_on = 1'b0;
    far_sym = fep_pkg::MLT_ZERO;
    col_seen = 1'b0;
    crs_seen = 1'b0;
    mismatches = 0;
    samples_checked = 0;
    seed = $urandom(32'h659A);
    // Loopback, NRZI enable, line-code bypass, scrambler off, full duplex
    cfg[0] = 5'h18;
    cfg[1] = 5'h09;
    cfg[2] = 5'h06;
    cfg[3] = 5'h02;
    cfg[4] = 5'h08;
    for (int c = 0; c < 5; c++)
    begin
      @(negedge sys_clk);
      sys_rst = 1'b1;
      basic_control_reg = 16'h0000;
      xcvr_config_reg = 16'h0000;
      basic_control_reg[fep_pkg::BASIC_CTRL_LOOPBACK_BIT] = cfg[c][4];
      xcvr_config_reg[fep_pkg::XCVR_NRZI_EN_BIT] = cfg[c][3];
      xcvr_config_reg[fep_pkg::XCVR_LINE_CODE_BYPASS_BIT] = cfg[c][2];
      xcvr_config_reg[fep_pkg::XCVR_SCRAMBLER_OFF_BIT] = cfg[c][1];
      full_duplex = cfg[c][0];
      repeat (12) @(negedge sys_clk);
      sys_rst = 1'b0;
      repeat (300) @(negedge sys_clk);
      check("line enable", {7'h00, !cfg[c][4]}, {7'h00, tx_line_en});
      if (cfg[c][4])
        check("isolated line", 8'h00, {6'h00, tx_line_sym});
      if (c == 2)
        for (int k = 0; k < 20; k++)
        begin
          @(negedge sys_clk);
          check("idle plain line", {6'h00, fep_pkg::MLT_PLUS}, {6'h00, tx_line_sym});
        end
      if (c == 3)
      begin
        lnz = 2'h3;
        pv = tx_line_sym;
        for (int k = 0; k < 16; k++)
        begin
          repeat (2) @(negedge sys_clk);
          if (pv != fep_pkg::MLT_ZERO)
          begin
            lnz = pv;
            ex = fep_pkg::MLT_ZERO;
          end
          else
            ex = (lnz == fep_pkg::MLT_PLUS) ? fep_pkg::MLT_MINUS : fep_pkg::MLT_PLUS;
          if (lnz != 2'h3)
            check("mlt level", {6'h00, ex}, {6'h00, tx_line_sym});
          pv = tx_line_sym;
        end
      end
      col_seen = 1'b0;
      crs_seen = 1'b0;
      mac.send_frame(8 + c * 4);
      for (int w = 0; w <= 2000 && mac.exp_q.size() != 0; w++)
      begin
        @(negedge sys_clk);
        if (w == 2000)
        begin
          check("receive drain timeout", 8'h00, 8'h01);
          close_out();
        end
      end
      repeat (200) @(negedge sys_clk);
      check("carrier seen", 8'h01, {7'h00, crs_seen});
      check("carrier after end", 8'h00, {7'h00, crs});
      check("collision seen", {7'h00, !cfg[c][0]}, {7'h00, col_seen});
    end
    for (int k = 0; k < 8; k++)
    begin
      @(negedge sys_clk);
      man_tx_bit = 1'($urandom);
      man_line_bit = 1'($urandom);
      speed_10m = 1'($urandom);
      basic_control_reg[fep_pkg::BASIC_CTRL_LOOPBACK_BIT] = 1'($urandom);
      @(negedge sys_clk);
      ex[0] = (speed_10m && basic_control_reg[fep_pkg::BASIC_CTRL_LOOPBACK_BIT]) ?
              man_tx_bit : man_line_bit;
      check("recovery feed", {7'h00, ex[0]}, {7'h00, man_cdr_bit});
    end
    // Remote loop with line code bypass echoes the far end level
    basic_control_reg = 16'h0000;
    xcvr_config_reg = 16'h0000;
    xcvr_config_reg[fep_pkg::XCVR_REMOTE_LOOP_BIT] = 1'b1;
    xcvr_config_reg[fep_pkg::XCVR_LINE_CODE_BYPASS_BIT] = 1'b1;
    far_on = 1'b1;
    for (int k = 0; k < 8; k++)
    begin
      far_sym = 1'($urandom) ? fep_pkg::MLT_PLUS : fep_pkg::MLT_ZERO;
      repeat (12) @(negedge sys_clk);
      check("remote loop line", {6'h00, far_sym}, {6'h00, tx_line_sym});
    end
    close_out();
  end
endmodule : testbench

// ---- verilog/fep_datapath.sv ----
// 100 Mb/s physical coding datapath: 4B/5B, scrambling, NRZI, MLT-3, carrier and loopback
`timescale 1ns/1ps

module fep_datapath #(
  parameter logic [fep_pkg::SEED_W-1:0] TX_SEED = 10'h3FF,
  parameter logic [fep_pkg::SEED_W-1:0] RX_SEED = 10'h3FF
) (
  // Clock and reset
  input  wire logic                 sys_clk,
  input  wire logic                 sys_rst,
  // Configuration
  input  wire logic [15:0]          basic_control_reg,
  input  wire logic [15:0]          xcvr_config_reg,
  input  wire logic                 full_duplex,
  input  wire logic                 speed_10m,
  // MII transmit
  input  wire fep_pkg::fep_mii_tx_s mii_tx,
  output logic                      tx_clk,
  // MII receive
  output fep_pkg::fep_mii_rx_s      mii_rx,
  output logic                      rx_clk,
  output logic                      crs,
  output logic                      col,
  // 100 Mb/s line
  output logic [1:0]                tx_line_sym,
  output logic                      tx_line_en,
  input  wire logic [1:0]           rx_line_sym,
  // 10 Mb/s recovery feed
  input  wire logic                 man_tx_bit,
  input  wire logic                 man_line_bit,
  output logic                      man_cdr_bit
);

  typedef struct packed {
    logic [3:0]           ph;
    logic                 tx_clk;
    fep_pkg::fep_tx_e     tx_st;
    logic [4:0]           sh;
    logic                 tx_nrzi;
    logic [1:0]           mlt_lvl;
    logic                 mlt_up;
    logic [1:0]           line_sym;
    logic                 line_en;
    logic [1:0]           rx_sym_prev;
    logic                 rx_rec;
    logic                 rx_rec_d;
    logic [9:0]           win;
    fep_pkg::fep_rx_e     rx_st;
    logic [2:0]           rx_bcnt;
    logic                 pend;
    logic [3:0]           pend_nib;
    fep_pkg::fep_mii_rx_s mii_rx;
    logic                 crs;
    logic                 col;
    logic                 man_cdr;
    logic [4:0]           lock_cnt;
  } fep_state_s;

  fep_state_s r_reg;
  fep_state_s r_next;

  logic       loopback;
  logic       remote_loop;
  logic       nrzi_en;
  logic       mlt_bypass;
  logic       scr_off;
  logic       bit_tick;
  logic       nib_end;
  logic       tx_key;
  logic       rx_key;
  logic       tx_scr;
  logic       mlt_dec;
  logic       rec_in;
  logic       rx_nrz;
  logic       rx_plain;
  logic       mlt_in;
  logic [4:0] rx_grp;
  logic [4:0] rx_dec;
  logic       rx_new;
  logic       rx_locked;

  assign loopback    = basic_control_reg[fep_pkg::BASIC_CTRL_LOOPBACK_BIT];
  assign remote_loop = xcvr_config_reg[fep_pkg::XCVR_REMOTE_LOOP_BIT];
  assign nrzi_en     = xcvr_config_reg[fep_pkg::XCVR_NRZI_EN_BIT];
  assign mlt_bypass  = xcvr_config_reg[fep_pkg::XCVR_LINE_CODE_BYPASS_BIT];
  assign scr_off     = xcvr_config_reg[fep_pkg::XCVR_SCRAMBLER_OFF_BIT];

  assign bit_tick = (4'(r_reg.ph % fep_pkg::PH_BITMOD) == fep_pkg::PH_BITEND);
  assign nib_end  = (r_reg.ph == fep_pkg::PH_LAST);
  assign rx_locked = (r_reg.lock_cnt == fep_pkg::LOCK_BITS);

  // Transmit scrambler runs one key bit per line bit
  fep_scrambler #(
    .SEED     (TX_SEED)
  ) u_tx_scr (
    .sys_clk  (sys_clk),
    .sys_rst  (sys_rst),
    .step     (bit_tick),
    .sync_en  (1'b0),
    .sync_bit (1'b0),
    .key      (tx_key)
  );

  // Receive descrambler seeds from idle only until locked, then free-runs
  fep_scrambler #(
    .SEED     (RX_SEED)
  ) u_rx_scr (
    .sys_clk  (sys_clk),
    .sys_rst  (sys_rst),
    .step     (bit_tick),
    .sync_en  (!rx_locked && !scr_off),
    .sync_bit (~rx_nrz),
    .key      (rx_key)
  );

  always_comb
  begin
    r_next   = r_reg;
    rx_new   = 1'b0;
    tx_scr   = scr_off ? r_reg.sh[4] : (r_reg.sh[4] ^ tx_key);
    mlt_dec  = mlt_bypass ? (rx_line_sym == fep_pkg::MLT_PLUS)
                          : (rx_line_sym != r_reg.rx_sym_prev);
    rec_in   = loopback ? r_reg.tx_nrzi : mlt_dec;
    rx_nrz   = nrzi_en ? (r_reg.rx_rec ^ r_reg.rx_rec_d) : r_reg.rx_rec;
    rx_plain = scr_off ? rx_nrz : (rx_nrz ^ rx_key);
    mlt_in   = remote_loop ? r_reg.rx_rec : r_reg.tx_nrzi;
    rx_grp   = {r_reg.win[3:0], rx_plain};
    rx_dec   = fep_pkg::fep_decode(rx_grp);

    // Nibble and bit timing
    r_next.ph     = nib_end ? 4'h0 : (r_reg.ph + 4'h1);
    r_next.tx_clk = (r_next.ph < fep_pkg::PH_HALF);

    if (bit_tick)
    begin
      // Serialize, NRZI and MLT-3 on the transmit side
      r_next.sh      = {r_reg.sh[3:0], 1'b0};
      r_next.tx_nrzi = nrzi_en ? (r_reg.tx_nrzi ^ tx_scr) : tx_scr;
      if (mlt_bypass)
        r_next.mlt_lvl = mlt_in ? fep_pkg::MLT_PLUS : fep_pkg::MLT_ZERO;
      else if (mlt_in)
      begin
        if (r_reg.mlt_lvl == fep_pkg::MLT_ZERO)
        begin
          r_next.mlt_lvl = r_reg.mlt_up ? fep_pkg::MLT_PLUS : fep_pkg::MLT_MINUS;
          r_next.mlt_up  = !r_reg.mlt_up;
        end
        else
          r_next.mlt_lvl = fep_pkg::MLT_ZERO;
      end

      // Receive recovery and packing
      r_next.rx_sym_prev = loopback ? fep_pkg::MLT_ZERO : rx_line_sym;
      r_next.rx_rec      = rec_in;
      r_next.rx_rec_d    = r_reg.rx_rec;
      r_next.win         = {r_reg.win[8:0], rx_plain};
      // Zeros of a start delimiter must never reseed the descrambler
      if (!rx_locked)
        r_next.lock_cnt = r_reg.lock_cnt + 5'h01;

      case (r_reg.rx_st)
        fep_pkg::RX_IDLE:
        begin
          if (rx_locked && fep_pkg::fep_two_zeros(r_next.win))
            r_next.rx_st = fep_pkg::RX_SYNC;
        end
        fep_pkg::RX_SYNC:
        begin
          if (r_next.win == fep_pkg::JK_PATTERN)
          begin
            r_next.rx_st   = fep_pkg::RX_DATA;
            r_next.rx_bcnt = 3'h0;
          end
          else if (r_next.win == fep_pkg::WIN_IDLE)
            r_next.rx_st = fep_pkg::RX_IDLE;
        end
        fep_pkg::RX_DATA:
        begin
          r_next.rx_bcnt = r_reg.rx_bcnt + 3'h1;
          if (r_reg.rx_bcnt == fep_pkg::BCNT_LAST)
          begin
            r_next.rx_bcnt = 3'h0;
            if (rx_grp == fep_pkg::CODE_T || rx_grp == fep_pkg::CODE_I)
              r_next.rx_st = fep_pkg::RX_IDLE;
            else if (rx_dec[4])
            begin
              r_next.pend     = 1'b1;
              rx_new          = 1'b1;
              r_next.pend_nib = rx_dec[3:0];
            end
          end
        end
        default:
          r_next.rx_st = fep_pkg::RX_IDLE;
      endcase
    end

    if (nib_end)
    begin
      // Present one received nibble per receive clock period
      r_next.mii_rx = '{dv: r_reg.pend, rxd: r_reg.pend_nib};
      // A group completing on the boundary wins over the clear
      if (!rx_new)
        r_next.pend = 1'b0;

      // Code-group selection at the transmit clock rising edge
      case (r_reg.tx_st)
        fep_pkg::TX_IDLE:
        begin
          if (mii_tx.en)
          begin
            r_next.sh    = fep_pkg::CODE_J;
            r_next.tx_st = fep_pkg::TX_SSD_K;
          end
          else
            r_next.sh = fep_pkg::CODE_I;
        end
        fep_pkg::TX_SSD_K:
        begin
          r_next.sh    = fep_pkg::CODE_K;
          r_next.tx_st = fep_pkg::TX_DATA;
        end
        fep_pkg::TX_DATA:
        begin
          if (mii_tx.en)
            r_next.sh = fep_pkg::fep_encode(mii_tx.txd);
          else
          begin
            r_next.sh    = fep_pkg::CODE_T;
            r_next.tx_st = fep_pkg::TX_ESD_R;
          end
        end
        fep_pkg::TX_ESD_R:
        begin
          r_next.sh    = fep_pkg::CODE_R;
          r_next.tx_st = fep_pkg::TX_IDLE;
        end
        default:
        begin
          r_next.sh    = fep_pkg::CODE_I;
          r_next.tx_st = fep_pkg::TX_IDLE;
        end
      endcase
    end

    // Carrier, collision, line isolation and 10 Mb/s feed
    r_next.crs = (r_reg.rx_st != fep_pkg::RX_IDLE) ||
                 (!full_duplex && (r_reg.tx_st != fep_pkg::TX_IDLE));
    r_next.col = !full_duplex && (r_reg.rx_st != fep_pkg::RX_IDLE) &&
                 (r_reg.tx_st != fep_pkg::TX_IDLE);
    r_next.line_en  = !loopback;
    r_next.line_sym = loopback ? fep_pkg::MLT_ZERO : r_next.mlt_lvl;
    r_next.man_cdr  = (loopback && speed_10m) ? man_tx_bit : man_line_bit;
  end

  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      r_reg     <= '0;
      r_reg.sh  <= fep_pkg::CODE_I;
      r_reg.ph  <= fep_pkg::PH_LAST;
      r_reg.win <= fep_pkg::WIN_IDLE;
    end
    else
      r_reg <= r_next;
  end

  assign tx_clk      = r_reg.tx_clk;
  assign rx_clk      = r_reg.tx_clk;
  assign mii_rx      = r_reg.mii_rx;
  assign crs         = r_reg.crs;
  assign col         = r_reg.col;
  assign tx_line_sym = r_reg.line_sym;
  assign tx_line_en  = r_reg.line_en;
  assign man_cdr_bit = r_reg.man_cdr;

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (sys_rst);

  AST_IDLE_FILL: assert property (
    nib_end && r_reg.tx_st == fep_pkg::TX_IDLE && !mii_tx.en |=> r_reg.sh == fep_pkg::CODE_I)
    else $error("idle group not loaded between frames");

  AST_SSD_JK: assert property (
    nib_end && r_reg.tx_st == fep_pkg::TX_IDLE && mii_tx.en
    |=> r_reg.sh == fep_pkg::CODE_J ##10 r_reg.sh == fep_pkg::CODE_K)
    else $error("frame did not start with J then K");

  AST_ESD_TR: assert property (
    nib_end && r_reg.tx_st == fep_pkg::TX_DATA && !mii_tx.en
    |=> r_reg.sh == fep_pkg::CODE_T ##10 r_reg.sh == fep_pkg::CODE_R)
    else $error("frame did not end with T then R");

  AST_NIB_PERIOD: assert property (
    $rose(r_reg.tx_clk) |-> ##10 $rose(r_reg.tx_clk))
    else $error("nibble clock period is not ten cycles");

  AST_NRZI_BYPASS: assert property (
    bit_tick && !nrzi_en |=> r_reg.tx_nrzi == $past(tx_scr))
    else $error("bypassed NRZI stage altered the bit");

  AST_MLT_HOLD: assert property (
    bit_tick && !mlt_bypass && !mlt_in |=> r_reg.mlt_lvl == $past(r_reg.mlt_lvl))
    else $error("line level moved on a zero bit");

  AST_FD_NO_COL: assert property (
    full_duplex |=> !col)
    else $error("collision raised in full duplex");

  AST_HD_COL: assert property (
    !full_duplex && r_reg.rx_st != fep_pkg::RX_IDLE && r_reg.tx_st != fep_pkg::TX_IDLE
    |=> col && crs)
    else $error("overlap in half duplex without collision");

  AST_FD_TX_NO_CRS: assert property (
    full_duplex && r_reg.rx_st == fep_pkg::RX_IDLE |=> !crs)
    else $error("carrier raised by transmit in full duplex");

  AST_LOOP_ISOLATE: assert property (
    loopback |=> !tx_line_en && tx_line_sym == fep_pkg::MLT_ZERO)
    else $error("line driven during internal loopback");

  COV_FRAME_START: cover property (r_reg.tx_st == fep_pkg::TX_SSD_K);
  COV_RX_DATA:     cover property (mii_rx.dv);
  COV_COLLISION:   cover property (col);
  COV_REMOTE_LOOP: cover property (remote_loop && bit_tick && mlt_in);

endmodule : fep_datapath

// ---- verilog/fep_pkg.sv ----
// Shared constants, types and code-group functions for the 100 Mb/s coding datapath
package fep_pkg;

  // Clocking and rates
  localparam int SYS_CLK_MHZ   = 250;
  localparam int BIT_RATE_MHZ  = 125;
  localparam int NIB_RATE_MHZ  = 25;
  localparam int CYC_PER_BIT   = SYS_CLK_MHZ / BIT_RATE_MHZ;
  localparam int CYC_PER_NIB   = SYS_CLK_MHZ / NIB_RATE_MHZ;
  localparam int GROUP_BITS    = 5;
  localparam int WIN_BITS      = 10;
  localparam int LFSR_W        = 11;
  localparam int SEED_W        = 10;

  localparam logic [3:0] PH_LAST   = 4'(CYC_PER_NIB - 1);
  localparam logic [3:0] PH_HALF   = 4'(CYC_PER_NIB / 2);
  localparam logic [3:0] PH_BITMOD = 4'(CYC_PER_BIT);
  localparam logic [3:0] PH_BITEND = 4'(CYC_PER_BIT - 1);
  localparam logic [2:0] BCNT_LAST = 3'(GROUP_BITS - 1);
  localparam logic [4:0] LOCK_BITS = 5'h1F;

  // Configuration bit positions
  localparam int BASIC_CTRL_LOOPBACK_BIT  = 14;
  localparam int XCVR_REMOTE_LOOP_BIT     = 9;
  localparam int XCVR_NRZI_EN_BIT         = 7;
  localparam int XCVR_LINE_CODE_BYPASS_BIT = 1;
  localparam int XCVR_SCRAMBLER_OFF_BIT   = 0;

  // Special code-groups, first transmitted bit in the MSB
  localparam logic [4:0] CODE_I = 5'h1F;
  localparam logic [4:0] CODE_J = 5'h18;
  localparam logic [4:0] CODE_K = 5'h11;
  localparam logic [4:0] CODE_T = 5'h0D;
  localparam logic [4:0] CODE_R = 5'h07;
  localparam logic [9:0] JK_PATTERN = 10'h311;
  localparam logic [9:0] WIN_IDLE   = 10'h3FF;

  // Line levels
  localparam logic [1:0] MLT_ZERO  = 2'h0;
  localparam logic [1:0] MLT_PLUS  = 2'h1;
  localparam logic [1:0] MLT_MINUS = 2'h2;

  typedef enum logic [1:0] {TX_IDLE, TX_SSD_K, TX_DATA, TX_ESD_R} fep_tx_e;
  typedef enum logic [1:0] {RX_IDLE, RX_SYNC, RX_DATA} fep_rx_e;

  typedef struct packed {
    logic       en;
    logic [3:0] txd;
  } fep_mii_tx_s;

  typedef struct packed {
    logic       dv;
    logic [3:0] rxd;
  } fep_mii_rx_s;

  typedef struct packed {
    logic [LFSR_W-1:0] s;
  } fep_lfsr_s;

  function automatic logic [4:0] fep_encode(input logic [3:0] nib);
    logic [4:0] c;
    c = CODE_I;
    case (nib)
      4'h0: c = 5'h1E;  4'h1: c = 5'h09;  4'h2: c = 5'h14;  4'h3: c = 5'h15;
      4'h4: c = 5'h0A;  4'h5: c = 5'h0B;  4'h6: c = 5'h0E;  4'h7: c = 5'h0F;
      4'h8: c = 5'h12;  4'h9: c = 5'h13;  4'hA: c = 5'h16;  4'hB: c = 5'h17;
      4'hC: c = 5'h1A;  4'hD: c = 5'h1B;  4'hE: c = 5'h1C;  4'hF: c = 5'h1D;
      default: c = CODE_I;
    endcase
    return c;
  endfunction : fep_encode

  // Returns {valid, nibble}
  function automatic logic [4:0] fep_decode(input logic [4:0] grp);
    logic [4:0] d;
    d = 5'h00;
    for (int i = 0; i < 16; i++)
    begin
      if (fep_encode(4'(i)) == grp)
        d = {1'b1, 4'(i)};
    end
    return d;
  endfunction : fep_decode

  // Two zeros at least two positions apart within the window
  function automatic logic fep_two_zeros(input logic [9:0] w);
    logic hit;
    hit = 1'b0;
    for (int i = 0; i < WIN_BITS; i++)
    begin
      for (int j = i + 2; j < WIN_BITS; j++)
      begin
        if (!w[i] && !w[j])
          hit = 1'b1;
      end
    end
    return hit;
  endfunction : fep_two_zeros

endpackage : fep_pkg

// ---- verilog/fep_scrambler.sv ----
// Bit-serial stream cipher key generator with receive-side self synchronisation
`timescale 1ns/1ps
module fep_scrambler #(
  parameter logic [fep_pkg::SEED_W-1:0] SEED = 10'h3FF
) (
  // Clock and reset
  input  wire logic sys_clk,
  input  wire logic sys_rst,
  // Control
  input  wire logic step,
  input  wire logic sync_en,
  input  wire logic sync_bit,
  // Key
  output logic      key
);

  fep_pkg::fep_lfsr_s r_reg;
  fep_pkg::fep_lfsr_s r_next;

  assign key = r_reg.s[fep_pkg::LFSR_W-1] ^ r_reg.s[fep_pkg::LFSR_W-3];

  always_comb
  begin
    r_next = r_reg;
    if (step)
    begin
      // While locking the known idle plaintext reveals the key directly
      r_next.s = {r_reg.s[fep_pkg::LFSR_W-2:0], sync_en ? sync_bit : key};
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
      r_reg <= '{s: {1'b1, SEED}};
    else
      r_reg <= r_next;
  end

endmodule : fep_scrambler
